// ### rtl/tfro_pkg.sv
// package for the thermal flag and rail override register block
// assumes a 32-bit axi4-lite slave port and a single 25 MHz clock
`default_nettype none
package tfro_pkg;
    // register indices: the byte address on the bus is four times the index
    localparam logic [7:0] IDX_THERMAL = 8'hec;
    localparam logic [7:0] IDX_OVERRIDE = 8'hee;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
    localparam logic [7:0] IDX_CONTROL = 8'hf2;
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] ADDR_THERMAL = {IDX_THERMAL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_OVERRIDE = {IDX_OVERRIDE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam int HOT_W = 6;
    localparam int RAIL_W = 8;
    localparam logic [1:0] THERMAL_RSVD_VAL = 2'h3;
    localparam logic [HOT_W-1:0] HOT_RESET = 6'h00;
    localparam logic [RAIL_W-1:0] OVERRIDE_RESET = 8'h00;
    localparam logic [HOT_W-1:0] IRQ_MASK_RESET = 6'h00;
    localparam logic MASK_SETTING_RESET = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } tfro_rd_t;
endpackage
`default_nettype wire

// ### rtl/tfro_regs.sv
// thermal warning flags and rail enable override registers behind axi4-lite
// assumes monitors give synchronous hot inputs and rail pins are synchronous
//
// Overview of operation
// R1: thermal register bits 7:6 always read one; writes ignored
// R2: bit 5 linear regulator one, bits 4..0 bucks five down to one
// R3: writing one clears a thermal flag; writing zero leaves it
// R4: override bits 7..0 map rails 12,11,10,9,8,7,5,4; zero means pin control
// R5: override one forces rail on only while mask setting is zero
// R6: override register at 0xee, resets to all zeros
// R7: thermal register at 0xec, flags reset to zero
// R8: hot monitor sets flag sticky; set wins over simultaneous clear
`timescale 1ns/1ns
`default_nettype none
module tfro_regs
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] hot_event,
    input wire logic [7:0] rail_enable_pin,
    output logic [7:0] rail_enable,
    output logic irq
);
    logic [9:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic [5:0] hot_q;
    logic [7:0] override_q;
    logic mask_setting_q;
    logic [5:0] irq_stat_q;
    logic [5:0] irq_mask_q;
    logic do_write;
    logic do_read;
    logic wr_thermal;
    logic wr_override;
    logic wr_mask;
    logic wr_control;
    logic rd_irq_stat;
    logic [5:0] hot_clr;
    tfro_pkg::tfro_rd_t rd_d;

    // write address and data are caught independently, then done together
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign wr_thermal = do_write && awaddr_q == tfro_pkg::ADDR_THERMAL && wstrb_q[0];
    assign wr_override = do_write && awaddr_q == tfro_pkg::ADDR_OVERRIDE && wstrb_q[0];
    assign wr_mask = do_write && awaddr_q == tfro_pkg::ADDR_IRQ_MASK && wstrb_q[0];
    assign wr_control = do_write && awaddr_q == tfro_pkg::ADDR_CONTROL && wstrb_q[0];
    assign rd_irq_stat = do_read && s_axi_araddr == tfro_pkg::ADDR_IRQ_STATUS;
    assign hot_clr = wr_thermal ? wdata_q[5:0] : 6'h00; // R3

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
            s_axi_awready <= 1'b0;
        end
        else if (do_write)
        begin
            aw_have_q <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            w_have_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_wready <= 1'b0;
        end
        else if (do_write)
        begin
            w_have_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_have_q && !s_axi_bvalid;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tfro_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
                tfro_pkg::ADDR_THERMAL,
                tfro_pkg::ADDR_OVERRIDE,
                tfro_pkg::ADDR_IRQ_STATUS,
                tfro_pkg::ADDR_IRQ_MASK,
                tfro_pkg::ADDR_CONTROL: s_axi_bresp <= tfro_pkg::RESP_OKAY;
                default: s_axi_bresp <= tfro_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // sticky hot flags: a new hot condition beats a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            hot_q <= tfro_pkg::HOT_RESET; // R7
        end
        else
        begin
            hot_q <= (hot_q & ~hot_clr) | hot_event; // R2 R3 R8
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            override_q <= tfro_pkg::OVERRIDE_RESET; // R6
        end
        else if (wr_override)
        begin
            override_q <= wdata_q[7:0]; // R4 R6
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            mask_setting_q <= tfro_pkg::MASK_SETTING_RESET;
        end
        else if (wr_control)
        begin
            mask_setting_q <= wdata_q[0];
        end
    end

    // override only applies while the pin mask setting is zero
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            rail_enable <= '0;
        end
        else
        begin
            rail_enable <= rail_enable_pin | (mask_setting_q ? 8'h00 : override_q); // R4 R5
        end
    end

    // interrupt status: any hot event is recorded; reading clears, new event wins
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            irq_stat_q <= '0;
        end
        else
        begin
            irq_stat_q <= (rd_irq_stat ? 6'h00 : irq_stat_q) | hot_event;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            irq_mask_q <= tfro_pkg::IRQ_MASK_RESET;
        end
        else if (wr_mask)
        begin
            irq_mask_q <= wdata_q[5:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(((rd_irq_stat ? 6'h00 : irq_stat_q) | hot_event) & irq_mask_q);
        end
    end

    always_comb
    begin
        rd_d.resp = tfro_pkg::RESP_OKAY;
        rd_d.data = '0;
        case (s_axi_araddr)
            tfro_pkg::ADDR_THERMAL: rd_d.data[7:0] = {tfro_pkg::THERMAL_RSVD_VAL, hot_q}; // R1
            tfro_pkg::ADDR_OVERRIDE: rd_d.data[7:0] = override_q;
            tfro_pkg::ADDR_IRQ_STATUS: rd_d.data[5:0] = irq_stat_q;
            tfro_pkg::ADDR_IRQ_MASK: rd_d.data[5:0] = irq_mask_q;
            tfro_pkg::ADDR_CONTROL: rd_d.data[0] = mask_setting_q;
            default: rd_d.resp = tfro_pkg::RESP_SLVERR;
        endcase
    end

    // one read at a time: arready only while no answer is pending
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= tfro_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d.data;
            s_axi_rresp <= rd_d.resp;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_rvalid <= !s_axi_rready;
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    AST_RSVD_ONES: assert property (@(posedge mclk) disable iff (!nrst) // R1
        $past(do_read) && $past(s_axi_araddr) == tfro_pkg::ADDR_THERMAL |-> s_axi_rdata[7:6] == 2'h3)
        else $error("thermal reserved bits did not read as ones");
    AST_HOT_SET: assert property (@(posedge mclk) disable iff (!nrst) // R2
        hot_event[5] |=> hot_q[5])
        else $error("hot event did not set its flag");
    AST_CLEAR_ONE: assert property (@(posedge mclk) disable iff (!nrst) // R3
        wr_thermal && wdata_q[0] && !hot_event[0] |=> !hot_q[0])
        else $error("write one did not clear flag");
    AST_ZERO_KEEPS: assert property (@(posedge mclk) disable iff (!nrst) // R3
        wr_thermal && !wdata_q[1] && hot_q[1] |=> hot_q[1])
        else $error("write zero changed a flag");
    sequence s_override_write;
        wr_override && wdata_q[7] && !mask_setting_q;
    endsequence
    AST_FORCE_ON: assert property (@(posedge mclk) disable iff (!nrst) // R5
        s_override_write ##1 !mask_setting_q |=> rail_enable[7])
        else $error("override did not force rail on");
    AST_MASK_BLOCKS: assert property (@(posedge mclk) disable iff (!nrst) // R5
        mask_setting_q && !rail_enable_pin[0] |=> !rail_enable[0])
        else $error("override applied while mask set");
    AST_PIN_CONTROL: assert property (@(posedge mclk) disable iff (!nrst) // R4
        !override_q[3] |=> rail_enable[3] == $past(rail_enable_pin[3]))
        else $error("rail did not follow its pin");
    AST_STICKY: assert property (@(posedge mclk) disable iff (!nrst) // R8
        hot_q[2] && !hot_clr[2] |=> hot_q[2])
        else $error("flag fell without clear");
    AST_OVR_RESET: assert property (@(posedge mclk) // R6 R7
        !nrst |=> override_q == 8'h00 && hot_q == 6'h00)
        else $error("register not reset to zero");
endmodule // tfro_regs
`default_nettype wire

// ### sim/thermal_flag_and_rail_override_regs_tb_top.sv
// self-checking bench for the thermal flag and rail override registers
// assumes tfro_regs with an axi4-lite slave port and one 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module thermal_flag_and_rail_override_regs_tb_top;
    logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v, rnd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [5:0] hot, acc, st, c;
    logic [7:0] pin, rail, o;
    int failures, n_compared;

    tfro_regs dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hot_event(hot),
        .rail_enable_pin(pin), .rail_enable(rail), .irq(irq));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // with the mask setting high the override is ignored
    function automatic logic [7:0] exp_rail(input logic [7:0] p, input logic [7:0] ov, input logic msk);
        return msk ? p : (p | ov);
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // bus tasks start on a fresh edge so a strobe is never assigned twice in one step
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rd_v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
        rd(a);
        chk("rdata", rd_v, exp);
        chk("rresp", {30'h0, resp}, {30'h0, tfro_pkg::RESP_OKAY});
    endtask

    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // whole run needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        stop_test();
    end

    initial
    begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        hot = '0;
        pin = '0;
        acc = '0;
        st = '0;
        rnd = 32'h4f52b612;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        rchk(tfro_pkg::ADDR_THERMAL, 32'hc0);
        rchk(tfro_pkg::ADDR_OVERRIDE, 32'h0);
        wr(10'h004, 32'hff);
        chk("bresp", {30'h0, resp}, {30'h0, tfro_pkg::RESP_SLVERR});
        rd(10'h004);
        chk("rresp", {30'h0, resp}, {30'h0, tfro_pkg::RESP_SLVERR});
        chk("rdata", rd_v, 32'h0);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            @(posedge mclk);
            hot <= rnd[5:0];
            @(posedge mclk);
            hot <= 6'h00;
            acc = acc | rnd[5:0];
            st = st | rnd[5:0];
            rchk(tfro_pkg::ADDR_THERMAL, {24'h0, 2'h3, acc});
            wr(tfro_pkg::ADDR_THERMAL, 32'h0);
            rchk(tfro_pkg::ADDR_THERMAL, {24'h0, 2'h3, acc});
            c = rnd[13:8];
            wr(tfro_pkg::ADDR_THERMAL, {24'h0, rnd[15:14], c});
            acc = acc & ~c;
            rchk(tfro_pkg::ADDR_THERMAL, {24'h0, 2'h3, acc});
            chk("irq", {31'h0, irq}, 32'h0);
        end
        // a hot condition held across the clearing write must survive it
        @(posedge mclk);
        hot <= 6'h01;
        wr(tfro_pkg::ADDR_THERMAL, 32'h3f);
        hot <= 6'h00;
        st = st | 6'h01;
        rchk(tfro_pkg::ADDR_THERMAL, 32'hc1);
        wr(tfro_pkg::ADDR_IRQ_MASK, 32'h3f);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h1);
        rchk(tfro_pkg::ADDR_IRQ_STATUS, {26'h0, st});
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            rnd = lfsr(rnd);
            o = (i == 0) ? 8'hff : rnd[7:0];
            wr(tfro_pkg::ADDR_OVERRIDE, {24'h0, o});
            rchk(tfro_pkg::ADDR_OVERRIDE, {24'h0, o});
            pin <= (i == 0) ? 8'h00 : rnd[15:8];
            repeat (3) @(posedge mclk);
            chk("rail", {24'h0, rail}, {24'h0, exp_rail(pin, o, 1'b0)});
            wr(tfro_pkg::ADDR_CONTROL, 32'h1);
            repeat (3) @(posedge mclk);
            chk("rail", {24'h0, rail}, {24'h0, exp_rail(pin, o, 1'b1)});
            wr(tfro_pkg::ADDR_CONTROL, 32'h0);
        end
        // a write without its low byte strobe must be answered but leave the register alone
        wstrb <= 4'h0;
        wr(tfro_pkg::ADDR_OVERRIDE, {24'h0, ~o});
        wstrb <= 4'hf;
        chk("bresp", {30'h0, resp}, {30'h0, tfro_pkg::RESP_OKAY});
        rchk(tfro_pkg::ADDR_OVERRIDE, {24'h0, o});
        // mid-run reset: a flag is still set and the override holds a value
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rchk(tfro_pkg::ADDR_THERMAL, 32'hc0);
        rchk(tfro_pkg::ADDR_OVERRIDE, 32'h0);
        chk("rail", {24'h0, rail}, {24'h0, exp_rail(pin, 8'h00, 1'b0)});
        stop_test();
    end
endmodule // thermal_flag_and_rail_override_regs_tb_top
`default_nettype wire
